// [usbsl_defs.svh]
// Register offsets, field positions, reset values and constants of the setup/sleep/frame register slice.
`ifndef USBSL_DEFS_SVH
`define USBSL_DEFS_SVH
`define USBSL_OFF_SETUP_AREA   12'h018
`define USBSL_OFF_SLEEP_ATTR   12'h088
`define USBSL_OFF_FRAME_NUM    12'h08C
`define USBSL_OFF_SLEEP_STATUS 12'h0A0
`define USBSL_OFF_SLEEP_CTRL   12'h0A4
`define USBSL_SETUP_MSB        8
`define USBSL_SETUP_LSB        3
`define USBSL_WAKE_BIT         8
`define USBSL_BESL_MSB         7
`define USBSL_BESL_LSB         4
`define USBSL_LINK_MSB         3
`define USBSL_LINK_LSB         0
`define USBSL_FRAME_MSB        10
`define USBSL_RAM_BASE_OFF     12'h100
`define USBSL_LINK_L1          4'h1
`define USBSL_RESET_SETUP      6'h00
`define USBSL_RESET_ATTR       9'h000
`define USBSL_RESET_FRAME      11'h000
`endif

// [usbsl_pkg.sv]
// Types shared by the setup/sleep/frame register slice.
`default_nettype none
package usbsl_pkg;
    // Handshake the slice gives to an LPM transaction.
    typedef enum logic [1:0] {USBSL_HS_NONE, USBSL_HS_ACK, USBSL_HS_NYET, USBSL_HS_ERRSTALL} usbsl_hs_t;
    // Attributes carried by an LPM token.
    typedef struct packed {
        logic       sleep_remote_wake_allowed;
        logic [3:0] sleep_service_latency;
        logic [3:0] sleep_link_state;
    } usbsl_lpm_t;
    // Result of one LPM transaction.
    typedef struct packed {
        usbsl_hs_t  hs;
        logic       sleep_entered;
    } usbsl_lpm_res_t;
endpackage
`default_nettype wire

// [usbsl_regs.sv]
// APB register slice: SETUP area offset, LPM attributes and handshake, last frame number.
//
// How it works
// - Six-bit writable SETUP offset in bits 8:3; bits 2:0 read zero.
// - SETUP start address is RAM base plus offset followed by three zero bits.
// - Packet buffer RAM sits 0x100 bytes above the controller base.
// - Offset addresses only SETUP data; other traffic uses its endpoint address.
// - Remote-wake bit of last acknowledged LPM token latched into bit 8.
// - Latency code of last acknowledged LPM token latched into bits 7:4.
// - Link state of last acknowledged LPM token latched into bits 3:0.
// - Frame number of each start-of-frame held in bits 10:0 until next.
// - ACK or NYET per software only for clean tokens with L1 state; else ERROR/STALL.
// - Sleep-entered flag set on an acknowledged L1 request.
`timescale 1ns/100ps
`default_nettype none
`include "usbsl_defs.svh"

module usbsl_regs
    import usbsl_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        setup_data_valid,
    input  wire logic [8:0]  endpoint_buf_addr,
    input  wire logic [2:0]  setup_byte_index,
    output logic      [11:0] buf_write_addr,
    input  wire logic        lpm_valid,
    input  wire logic        lpm_ext_ok,
    input  wire logic        lpm_token_ok,
    input  wire usbsl_lpm_t  lpm_attr,
    output usbsl_lpm_res_t   lpm_result,
    input  wire logic        sleep_exit,
    input  wire logic        sof_valid,
    input  wire logic [10:0] sof_frame
);
    logic [5:0]     setup_off_q,   setup_off_d;
    usbsl_lpm_t     attr_q,        attr_d;
    logic [10:0]    frame_q,       frame_d;
    logic           ack_sel_q,     ack_sel_d;
    logic           entered_q,     entered_d;
    usbsl_lpm_res_t res_q,         res_d;
    logic [11:0]    waddr_q,       waddr_d;
    logic [31:0]    rdata_q,       rdata_d;
    logic           ready_q,       ready_d;
    logic           err_q,         err_d;
    logic           wr_setup;
    logic           wr_ctrl;
    logic           lpm_good;

    // Writes are decoded in the access phase while pready stands, so they land at the very edge at which the
    // master sees pready high; a transfer that never completes leaves the registers untouched.
    assign wr_setup = psel && penable && ready_q && pwrite && paddr == `USBSL_OFF_SETUP_AREA;
    assign wr_ctrl  = psel && penable && ready_q && pwrite && paddr == `USBSL_OFF_SLEEP_CTRL;
    // Only an error-free token pair asking for L1 may be answered positively.
    assign lpm_good = lpm_ext_ok && lpm_token_ok && lpm_attr.sleep_link_state == `USBSL_LINK_L1;

    // Next values of all state; read data is captured in setup so that it stands together with pready.
    always_comb begin
        setup_off_d = setup_off_q;
        ack_sel_d   = ack_sel_q;
        attr_d      = attr_q;
        frame_d     = frame_q;
        entered_d   = entered_q;
        res_d       = '{hs: USBSL_HS_NONE, sleep_entered: entered_q};
        rdata_d     = 32'h00000000;
        ready_d     = 1'b0;
        err_d       = 1'b0;
        if (wr_setup) begin
            setup_off_d = pwdata[`USBSL_SETUP_MSB:`USBSL_SETUP_LSB];
        end
        if (wr_ctrl) begin
            ack_sel_d = pwdata[0];
        end
        if (sleep_exit) begin
            entered_d = 1'b0;
        end
        if (lpm_valid) begin
            if (!lpm_good) begin
                res_d.hs = USBSL_HS_ERRSTALL;
            end else if (ack_sel_q) begin
                res_d.hs  = USBSL_HS_ACK;
                attr_d    = lpm_attr;
                entered_d = 1'b1;
            end else begin
                res_d.hs = USBSL_HS_NYET;
            end
        end
        res_d.sleep_entered = entered_d;
        if (sof_valid) begin
            frame_d = sof_frame;
        end
        // Address mux: SETUP bytes use the software offset, all else its endpoint address.
        if (setup_data_valid) begin
            waddr_d = `USBSL_RAM_BASE_OFF + {3'b000, setup_off_q, 3'b000} + {9'h000, setup_byte_index};
        end else begin
            waddr_d = `USBSL_RAM_BASE_OFF + {3'b000, endpoint_buf_addr};
        end
        if (psel && !penable) begin
            ready_d = 1'b1;
            case (paddr)
                `USBSL_OFF_SETUP_AREA:   rdata_d = {23'h000000, setup_off_q, 3'h0};
                `USBSL_OFF_SLEEP_ATTR:   rdata_d = {23'h000000, attr_q};
                `USBSL_OFF_FRAME_NUM:    rdata_d = {21'h000000, frame_q};
                `USBSL_OFF_SLEEP_STATUS: rdata_d = {31'h00000000, entered_q};
                `USBSL_OFF_SLEEP_CTRL:   rdata_d = {31'h00000000, ack_sel_q};
                default:                 err_d   = 1'b1;
            endcase
            // Writes to read-only registers are refused the same way as unmapped addresses.
            if (pwrite && paddr != `USBSL_OFF_SETUP_AREA && paddr != `USBSL_OFF_SLEEP_CTRL) begin
                err_d = 1'b1;
            end
        end
    end

    // Register stage; every output comes straight from here.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_off_q <= `USBSL_RESET_SETUP;
            attr_q      <= `USBSL_RESET_ATTR;
            frame_q     <= `USBSL_RESET_FRAME;
            ack_sel_q   <= 1'b0;
            entered_q   <= 1'b0;
            res_q       <= '{hs: USBSL_HS_NONE, sleep_entered: 1'b0};
            waddr_q     <= 12'h000;
            rdata_q     <= 32'h00000000;
            ready_q     <= 1'b0;
            err_q       <= 1'b0;
        end else begin
            setup_off_q <= setup_off_d;
            attr_q      <= attr_d;
            frame_q     <= frame_d;
            ack_sel_q   <= ack_sel_d;
            entered_q   <= entered_d;
            res_q       <= res_d;
            waddr_q     <= waddr_d;
            rdata_q     <= rdata_d;
            ready_q     <= ready_d;
            err_q       <= err_d;
        end
    end

    assign prdata         = rdata_q;
    assign pready         = ready_q;
    assign pslverr        = err_q;
    assign buf_write_addr = waddr_q;
    assign lpm_result     = res_q;

    // Software's SETUP offset lands exactly as written; the reserved low bits are dropped.
    a_setup_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_setup |=> setup_off_q == $past(pwdata[`USBSL_SETUP_MSB:`USBSL_SETUP_LSB]))
        else $error("setup offset not stored");

    // A read of the SETUP offset shows the field in place and zeros everywhere else.
    a_setup_rdata: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == `USBSL_OFF_SETUP_AREA)
        |=> prdata == {23'h000000, $past(setup_off_q), 3'h0})
        else $error("setup offset read wrong");

    // The byte index shows in the low bits, so the area always starts on an eight-byte boundary.
    a_setup_addr: assert property (@(posedge pclk) disable iff (!presetn)
        setup_data_valid |=> buf_write_addr[2:0] == $past(setup_byte_index))
        else $error("setup area misaligned");

    // The first byte of the area sits at the RAM base plus the scaled offset.
    a_ram_base: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_data_valid && setup_byte_index == 3'h0)
        |=> buf_write_addr == `USBSL_RAM_BASE_OFF + {3'h0, $past(setup_off_q), 3'h0})
        else $error("setup address wrong");

    // Other traffic ignores the offset. The guard skips the edges around reset release, where the
    // address register still holds its reset value although the inputs already select an endpoint.
    a_ep_addr: assert property (@(posedge pclk) disable iff (!presetn)
        (!setup_data_valid && $past(presetn))
        |=> buf_write_addr == `USBSL_RAM_BASE_OFF + {3'h0, $past(endpoint_buf_addr)})
        else $error("endpoint address wrong");

    // A clean L1 request answered with ACK loads all three attribute fields.
    a_attr_ack: assert property (@(posedge pclk) disable iff (!presetn)
        (lpm_valid && lpm_ext_ok && lpm_token_ok && lpm_attr.sleep_link_state == `USBSL_LINK_L1 && ack_sel_q)
        |=> attr_q == $past(lpm_attr) && lpm_result.hs == USBSL_HS_ACK)
        else $error("attributes not latched on ack");

    // Without an acknowledged token the attributes never move.
    a_attr_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(lpm_valid && lpm_ext_ok && lpm_token_ok && lpm_attr.sleep_link_state == `USBSL_LINK_L1 && ack_sel_q)
        |=> $stable(attr_q))
        else $error("attributes changed without ack");

    // Each start-of-frame packet loads its number at once.
    a_frame_load: assert property (@(posedge pclk) disable iff (!presetn)
        sof_valid |=> frame_q == $past(sof_frame))
        else $error("frame number not captured");

    // Between start-of-frame packets the captured number stays put.
    a_frame_hold: assert property (@(posedge pclk) disable iff (!presetn)
        sof_valid ##1 !sof_valid [*2] |-> frame_q == $past(sof_frame, 2))
        else $error("frame number not held");

    // Faulty tokens or a reserved link state get ERROR/STALL and change nothing.
    a_bad_lpm: assert property (@(posedge pclk) disable iff (!presetn)
        (lpm_valid && !(lpm_ext_ok && lpm_token_ok && lpm_attr.sleep_link_state == `USBSL_LINK_L1))
        |=> lpm_result.hs == USBSL_HS_ERRSTALL && $stable(attr_q))
        else $error("bad token answered");

    // A clean request while software selects NYET is answered NYET and leaves the attributes alone.
    a_nyet_answer: assert property (@(posedge pclk) disable iff (!presetn)
        (lpm_valid && lpm_ext_ok && lpm_token_ok && lpm_attr.sleep_link_state == `USBSL_LINK_L1 && !ack_sel_q)
        |=> lpm_result.hs == USBSL_HS_NYET && $stable(attr_q))
        else $error("clean token not answered with NYET");

    // An acknowledged L1 entry sets the flag, even against a clear in the same cycle.
    a_sleep_set: assert property (@(posedge pclk) disable iff (!presetn)
        (lpm_valid && lpm_ext_ok && lpm_token_ok && lpm_attr.sleep_link_state == `USBSL_LINK_L1 && ack_sel_q)
        |=> entered_q && lpm_result.sleep_entered)
        else $error("sleep flag not set");

    // A clear with no LPM traffic in the same cycle drops the flag on both views.
    a_sleep_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep_exit && !lpm_valid) |=> !entered_q && !lpm_result.sleep_entered)
        else $error("sleep flag not cleared");
endmodule // usbsl_regs
`default_nettype wire

// [usbsl_host_model.sv]
// Host-side model that issues LPM and start-of-frame traffic.
`timescale 1ns/100ps
`default_nettype none
module usbsl_host_model
    import usbsl_pkg::*;
(
    input  wire logic   pclk,
    output logic        lpm_valid,
    output logic        lpm_ext_ok,
    output logic        lpm_token_ok,
    output usbsl_lpm_t  lpm_attr,
    output logic        sof_valid,
    output logic [10:0] sof_frame
);
    // All lines start quiet, the check lines cleared too, so a stray pulse reads as a faulty token.
    initial begin
        {lpm_valid, lpm_ext_ok, lpm_token_ok, lpm_attr, sof_valid, sof_frame} = '0;
    end

    // One LPM transaction; data lines go inverted afterwards so stale attributes never look fresh.
    task automatic lpm(input logic ext, input logic tok, input usbsl_lpm_t a);
        @(posedge pclk);
        {lpm_valid, lpm_ext_ok, lpm_token_ok, lpm_attr} <= {1'b1, ext, tok, a};
        @(posedge pclk);
        {lpm_valid, lpm_attr} <= {1'b0, ~a};
    endtask

    // One start-of-frame packet carrying frame number f.
    task automatic sof(input logic [10:0] f);
        @(posedge pclk);
        {sof_valid, sof_frame} <= {1'b1, f};
        @(posedge pclk);
        {sof_valid, sof_frame} <= {1'b0, ~f};
    endtask
endmodule // usbsl_host_model
`default_nettype wire

// [usbsl_regs_bench.sv]
// Self-checking bench for the setup, sleep and frame register slice.
`timescale 1ns/100ps
`default_nettype none
module usbsl_regs_bench;
    import usbsl_pkg::*;
    logic           pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]    paddr = 12'h000, buf_write_addr;
    logic [31:0]    pwdata = 32'h0, prdata, rd;
    logic           pready, pslverr, er, setup_data_valid = 1'b0, sleep_exit = 1'b0;
    logic [8:0]     endpoint_buf_addr = 9'h000;
    logic [2:0]     setup_byte_index = 3'h0;
    logic           lpm_valid, lpm_ext_ok, lpm_token_ok, sof_valid;
    logic [10:0]    sof_frame;
    usbsl_lpm_t     lpm_attr;
    usbsl_lpm_res_t lpm_result;
    int             err_total = 0, num_checks = 0;

    // A 4 ns clock.
    always #2 pclk = ~pclk;

    usbsl_regs i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .setup_data_valid, .endpoint_buf_addr, .setup_byte_index, .buf_write_addr, .lpm_valid,
        .lpm_ext_ok, .lpm_token_ok, .lpm_attr, .lpm_result, .sleep_exit, .sof_valid, .sof_frame);
    usbsl_host_model i_host (.pclk, .lpm_valid, .lpm_ext_ok, .lpm_token_ok, .lpm_attr, .sof_valid, .sof_frame);

    // Compares a value with its expectation and counts the outcome.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer, entered just after an edge; an idle edge follows so calls never collide.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask

    // Reads a register and checks both data and error response.
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk(32'(er), 32'h0);
    endtask

    // Runs one LPM transaction and checks the handshake in the cycle it stands.
    task automatic lpmc(input logic ext, input logic tok, input usbsl_lpm_t a, input usbsl_hs_t hs);
        i_host.lpm(ext, tok, a);
        #1 chk(32'(lpm_result.hs), 32'(hs));
        @(posedge pclk);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // The whole sequence needs well under 1000 cycles, so 5000 marks a hang.
    initial begin
        #20000;
        err_total++;
        end_of_test;
    end

    // Main sequence of tests.
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(12'h018, 32'h0);
        rchk(12'h088, 32'h0);
        rchk(12'h08C, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(32'(er), 32'h1);
        $display("test reset done");
        apb(1'b1, 12'h018, 32'hFFFF_FFFF);
        chk(32'(er), 32'h0);
        rchk(12'h018, 32'h0000_01F8);
        apb(1'b1, 12'h088, 32'hFFFF_FFFF);
        chk(32'(er), 32'h1);
        {setup_data_valid, setup_byte_index, endpoint_buf_addr} <= {1'b1, 3'h7, 9'h040};
        repeat (2) @(posedge pclk);
        chk(32'(buf_write_addr), 32'h2FF);
        setup_byte_index <= 3'h0;
        repeat (2) @(posedge pclk);
        chk(32'(buf_write_addr), 32'h2F8);
        setup_data_valid <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(32'(buf_write_addr), 32'h140);
        $display("test setup offset done");
        // Every latency code passes through an acknowledged token.
        apb(1'b1, 12'h0A4, 32'h1);
        rchk(12'h0A4, 32'h1);
        for (int k = 0; k < 16; k++) begin
            lpmc(1'b1, 1'b1, {k[0], k[3:0], 4'h1}, USBSL_HS_ACK);
            rchk(12'h088, {23'h0, k[0], k[3:0], 4'h1});
        end
        rchk(12'h0A0, 32'h1);
        chk(32'(lpm_result.sleep_entered), 32'h1);
        lpmc(1'b1, 1'b1, 9'h0A2, USBSL_HS_ERRSTALL);
        lpmc(1'b0, 1'b1, 9'h021, USBSL_HS_ERRSTALL);
        lpmc(1'b1, 1'b0, 9'h021, USBSL_HS_ERRSTALL);
        apb(1'b1, 12'h0A4, 32'h0);
        lpmc(1'b1, 1'b1, 9'h051, USBSL_HS_NYET);
        rchk(12'h088, 32'h0000_01F1);
        sleep_exit <= 1'b1;
        @(posedge pclk);
        sleep_exit <= 1'b0;
        @(posedge pclk);
        rchk(12'h0A0, 32'h0);
        chk(32'(lpm_result.sleep_entered), 32'h0);
        // A clear in the very cycle of an acknowledged L1 entry must lose to the entry.
        apb(1'b1, 12'h0A4, 32'h1);
        fork
            i_host.lpm(1'b1, 1'b1, 9'h131);
            begin
                @(posedge pclk);
                sleep_exit <= 1'b1;
                @(posedge pclk);
                sleep_exit <= 1'b0;
            end
        join
        rchk(12'h0A0, 32'h1);
        rchk(12'h088, 32'h0000_0131);
        $display("test sleep attributes done");
        i_host.sof(11'h7FF);
        rchk(12'h08C, 32'h0000_07FF);
        i_host.sof(11'h2A5);
        repeat (3) @(posedge pclk);
        rchk(12'h08C, 32'h0000_02A5);
        $display("test frame number done");
        end_of_test;
    end
endmodule // usbsl_regs_bench
`default_nettype wire
